// ### sub_exec_core.v
// Execution core for byte subtract instructions with an AXI4-Lite slave.
// Assumes one clock, a synchronous active-low reset and a single AXI master.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sub_exec_defs.vh"
module sub_exec_core #(
  parameter ADDR_W = 12                      // Data memory address width.
) (
  // Clock and reset
  input  wire        aclk,                   // Core clock.
  input  wire        aresetn,                // Synchronous reset, active low.
  // Write address channel
  input  wire [7:0]  s_axi_awaddr,           // Write byte address.
  input  wire        s_axi_awvalid,          // Write address valid.
  output wire        s_axi_awready,          // Write address ready.
  // Write data channel
  input  wire [31:0] s_axi_wdata,            // Write data.
  input  wire [3:0]  s_axi_wstrb,            // Byte enables.
  input  wire        s_axi_wvalid,           // Write data valid.
  output wire        s_axi_wready,           // Write data ready.
  // Write response channel
  output reg  [1:0]  s_axi_bresp,            // Write response.
  output reg         s_axi_bvalid,           // Write response valid.
  input  wire        s_axi_bready,           // Write response ready.
  // Read address channel
  input  wire [7:0]  s_axi_araddr,           // Read byte address.
  input  wire        s_axi_arvalid,          // Read address valid.
  output wire        s_axi_arready,          // Read address ready.
  // Read data channel
  output reg  [31:0] s_axi_rdata,            // Read data.
  output reg  [1:0]  s_axi_rresp,            // Read response.
  output reg         s_axi_rvalid,           // Read data valid.
  input  wire        s_axi_rready            // Read data ready.
);

  // --------------------------------------------------------------------------
  // Phase states
  // --------------------------------------------------------------------------
  localparam [2:0] PH_IDLE = 3'h0;           // Waiting for an instruction.
  localparam [2:0] PH_Q1   = 3'h1;           // Decode.
  localparam [2:0] PH_Q2   = 3'h2;           // Read operand.
  localparam [2:0] PH_Q3   = 3'h3;           // Process data.
  localparam [2:0] PH_Q4   = 3'h4;           // Write destination.

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg [7:0]        data_mem [0:(1<<ADDR_W)-1]; // File registers.
  reg [2:0]        phase_reg;                // Instruction phase.
  reg [15:0]       instr_reg;                // Instruction word.
  reg [7:0]        work_reg;                 // Working register.
  reg [4:0]        status_reg;               // N, OV, Z, DC, C.
  reg [3:0]        bank_select_reg;          // Bank select.
  reg              ext_en_reg;               // Extended set enable.
  reg              bad_op_reg;               // Last word not in this group.
  reg [ADDR_W-1:0] index_base_reg;           // Base for indexed literal offset.
  reg [ADDR_W-1:0] mem_addr_reg;             // Bus window address.
  reg [ADDR_W-1:0] eff_addr_reg;             // Decoded file address.
  reg [1:0]        op_kind_reg;              // Decoded operation.
  reg [7:0]        operand_reg;              // Fetched file or literal byte.
  reg [7:0]        result_reg;               // Computed result.
  reg [4:0]        flags_reg;                // Computed flags.
  // Bus state
  reg              aw_held_reg;              // Write address captured.
  reg              w_held_reg;               // Write data captured.
  reg [7:0]        aw_addr_reg;              // Captured write address.
  reg [31:0]       w_data_reg;               // Captured write data.
  reg [3:0]        w_strb_reg;               // Captured strobes.

  localparam [1:0] OPK_FILE_MINUS_WORK = 2'h0; // File minus working.
  localparam [1:0] OPK_WORK_MINUS_FILE = 2'h1; // Working minus file minus borrow.
  localparam [1:0] OPK_LIT_MINUS_WORK  = 2'h2; // Literal minus working.
  localparam [1:0] OPK_NONE            = 2'h3; // Not in this group.

  // --------------------------------------------------------------------------
  // Decode of the instruction word
  // --------------------------------------------------------------------------
  wire [7:0]  op_hi    = instr_reg[15:8];    // Opcode byte.
  wire [7:0]  op_f     = instr_reg[7:0];     // File address or literal.
  wire        op_dest  = instr_reg[`OP_BIT_DEST];   // Destination bit.
  wire        op_acc   = instr_reg[`OP_BIT_ACCESS]; // Access bit.
  reg  [1:0]  kind_next;                     // Decoded kind.
  reg  [ADDR_W-1:0] addr_next;               // Decoded address.

  // Classifies the opcode and builds the effective file address.
  always @*
  begin
    if ((op_hi & `OP_MASK_FILE) == `OP_WORK_FILE)
      kind_next = OPK_FILE_MINUS_WORK;
    else if ((op_hi & `OP_MASK_FILE) == `OP_FILE_BORROW)
      kind_next = OPK_WORK_MINUS_FILE;
    else if (op_hi == `OP_WORK_LIT)
      kind_next = OPK_LIT_MINUS_WORK;
    else
      kind_next = OPK_NONE;
    if (op_acc)
      addr_next = {bank_select_reg, op_f};
    else if (ext_en_reg && op_f <= `ACC_LOW_LAST)
      addr_next = index_base_reg + {{(ADDR_W-8){1'b0}}, op_f};
    else if (op_f <= `ACC_LOW_LAST)
      addr_next = {{(ADDR_W-8){1'b0}}, op_f};
    else
      addr_next = {`ACC_HIGH_PAGE, op_f};     // High half of the access bank.
  end

  // --------------------------------------------------------------------------
  // Arithmetic
  // --------------------------------------------------------------------------
  wire        sub_file   = (op_kind_reg == OPK_WORK_MINUS_FILE);
  wire [7:0]  sub_a      = sub_file ? work_reg : operand_reg;  // Minuend.
  wire [7:0]  sub_b      = sub_file ? operand_reg : work_reg;  // Subtrahend.
  wire        sub_cin    = sub_file ? status_reg[`ST_CARRY] : 1'b1;
  wire [7:0]  sub_res;                       // Difference.
  wire        f_c;                           // Carry out.
  wire        f_dc;                          // Digit carry.
  wire        f_ov;                          // Overflow.
  wire        f_n;                           // Negative.
  wire        f_z;                           // Zero.

  // Shared subtractor for all three operations.
  sub_flag_unit #(
    .WIDTH (8)
  ) u_sub (
    .minuend     (sub_a),
    .subtrahend  (sub_b),
    .carry_in    (sub_cin),
    .result      (sub_res),
    .carry_out   (f_c),
    .digit_carry (f_dc),
    .overflow    (f_ov),
    .negative    (f_n),
    .zero        (f_z)
  );

  // --------------------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------------------
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire busy     = (phase_reg != PH_IDLE);   // Instruction in flight.
  wire wr_fire  = aw_held_reg && w_held_reg; // Both halves present.
  wire wr_lane0 = w_strb_reg[0];            // Only the low byte lane matters.
  wire wr_ok    = !busy || (aw_addr_reg == `OFS_CTRL); // Others locked while busy.

  // --------------------------------------------------------------------------
  // Phase sequencer, working register, flags and memory
  // --------------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_reg       <= PH_IDLE;
      instr_reg       <= 16'h0000;
      work_reg        <= `RST_WORK;
      status_reg      <= `RST_STATUS;
      bank_select_reg <= `RST_BANK_SEL;
      ext_en_reg      <= 1'b0;
      bad_op_reg      <= 1'b0;
      index_base_reg  <= `RST_INDEX_BASE;
      mem_addr_reg    <= {ADDR_W{1'b0}};
      eff_addr_reg    <= {ADDR_W{1'b0}};
      op_kind_reg     <= OPK_NONE;
      operand_reg     <= 8'h00;
      result_reg      <= 8'h00;
      flags_reg       <= 5'h00;
    end
    else
    begin
      // Four phases for every instruction of this group.
      case (phase_reg)
        PH_Q1:
        begin
          op_kind_reg  <= kind_next;
          eff_addr_reg <= addr_next;
          bad_op_reg   <= (kind_next == OPK_NONE);
          phase_reg    <= (kind_next == OPK_NONE) ? PH_IDLE : PH_Q2;
        end
        PH_Q2:
        begin
          // Literal comes from the word, otherwise the file is read.
          operand_reg <= (op_kind_reg == OPK_LIT_MINUS_WORK) ? op_f
                                                              : data_mem[eff_addr_reg];
          phase_reg   <= PH_Q3;
        end
        PH_Q3:
        begin
          result_reg <= sub_res;
          flags_reg  <= {f_n, f_ov, f_z, f_dc, f_c};
          phase_reg  <= PH_Q4;
        end
        PH_Q4:
        begin
          status_reg <= flags_reg;
          if (op_kind_reg == OPK_LIT_MINUS_WORK || !op_dest)
            work_reg <= result_reg;
          else
            data_mem[eff_addr_reg] <= result_reg;
          phase_reg  <= PH_IDLE;
        end
        default:
          phase_reg <= PH_IDLE;
      endcase
      // Register writes from the bus, refused while an instruction runs, except to the control register.
      if (wr_fire && !s_axi_bvalid && wr_ok && wr_lane0)
      begin
        if (aw_addr_reg == `OFS_INSTR)
        begin
          instr_reg <= w_data_reg[15:0];
          phase_reg <= PH_Q1;
        end
        else if (aw_addr_reg == `OFS_WORK)
          work_reg <= w_data_reg[7:0];
        else if (aw_addr_reg == `OFS_STATUS)
          status_reg <= w_data_reg[4:0];
        else if (aw_addr_reg == `OFS_BANK_SEL)
          bank_select_reg <= w_data_reg[3:0];
        else if (aw_addr_reg == `OFS_CTRL)
          ext_en_reg <= w_data_reg[`CT_EXT_EN];
        else if (aw_addr_reg == `OFS_INDEX_BASE)
          index_base_reg <= w_data_reg[ADDR_W-1:0];
        else if (aw_addr_reg == `OFS_MEM_ADDR)
          mem_addr_reg <= w_data_reg[ADDR_W-1:0];
        else if (aw_addr_reg == `OFS_MEM_DATA)
          data_mem[mem_addr_reg] <= w_data_reg[7:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Write channel capture and response
  // --------------------------------------------------------------------------
  wire wr_known = (aw_addr_reg[1:0] == 2'h0) && (aw_addr_reg <= `OFS_MEM_DATA);

  // Holds address and data until both have arrived, then answers.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire && !s_axi_bvalid)
      begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_known && wr_ok) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  reg [31:0] rd_word;                        // Selected read value.
  reg        rd_known;                       // Address is mapped.

  // Selects the register named by the read address.
  always @*
  begin
    rd_word  = 32'h0000_0000;
    rd_known = 1'b1;
    if (s_axi_araddr == `OFS_INSTR)
      rd_word = {16'h0000, instr_reg};
    else if (s_axi_araddr == `OFS_WORK)
      rd_word = {24'h000000, work_reg};
    else if (s_axi_araddr == `OFS_STATUS)
      rd_word = {27'h0, status_reg};
    else if (s_axi_araddr == `OFS_BANK_SEL)
      rd_word = {28'h0000000, bank_select_reg};
    else if (s_axi_araddr == `OFS_CTRL)
      rd_word = {29'h0, bad_op_reg, busy, ext_en_reg};
    else if (s_axi_araddr == `OFS_INDEX_BASE)
      rd_word = {{(32-ADDR_W){1'b0}}, index_base_reg};
    else if (s_axi_araddr == `OFS_MEM_ADDR)
      rd_word = {{(32-ADDR_W){1'b0}}, mem_addr_reg};
    else if (s_axi_araddr == `OFS_MEM_DATA)
      rd_word = {24'h000000, data_mem[mem_addr_reg]};
    else
      rd_known = 1'b0;
  end

  // Registers the read answer one cycle after the address is taken.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ### sub_exec_core_props.sv
// Checker for the subtract core: bus handshakes and status read-back relations.
// Assumes a bind to sub_exec_core with one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "sub_exec_defs.vh"
module sub_exec_core_props (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Write channels
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  // Read channels
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [7:0] rd_addr_reg;                     // Address of the read now answered.
  // ---------------------------------------------------------------------------
  // Read address capture
  // ---------------------------------------------------------------------------
  // Keeps the address so read data can be tied to the register it came from.
  always @(posedge aclk)
  begin
    if (!aresetn)
      rd_addr_reg <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready)
      rd_addr_reg <= s_axi_araddr;
  end
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write response dropped early.");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("Read data dropped early.");
  property p_r_answer;
    s_ar_take |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("Read answer late.");
  // Both halves are captured first, the response is raised on the next edge.
  property p_b_answer;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("Write answer late.");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("Write taken during response.");
  property p_unmapped;
    s_axi_rvalid && rd_addr_reg >= 8'h20 |-> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("Unmapped read not refused.");
  property p_zero_flags;
    s_axi_rvalid && rd_addr_reg == `OFS_STATUS && s_axi_rdata[`ST_ZERO]
      |-> s_axi_rdata[`ST_CARRY] && !s_axi_rdata[`ST_NEG];
  endproperty
  a_zero_flags: assert property (p_zero_flags) else $error("Zero flag pairing wrong.");
  property p_status_width;
    s_axi_rvalid && rd_addr_reg == `OFS_STATUS |-> s_axi_rdata[31:5] == 27'h0;
  endproperty
  a_status_width: assert property (p_status_width) else $error("Status upper bits set.");
endmodule
bind sub_exec_core sub_exec_core_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ### sub_exec_defs.vh
// Constants for the byte subtract execution block: register offsets, field
// positions, reset values, opcode patterns and addressing limits.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SUB_EXEC_DEFS_VH
`define SUB_EXEC_DEFS_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the AXI4-Lite bus
// ----------------------------------------------------------------------------
`define OFS_INSTR      8'h00
`define OFS_WORK       8'h04
`define OFS_STATUS     8'h08
`define OFS_BANK_SEL   8'h0C
`define OFS_CTRL       8'h10
`define OFS_INDEX_BASE 8'h14
`define OFS_MEM_ADDR   8'h18
`define OFS_MEM_DATA   8'h1C

// ----------------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------------
`define ST_CARRY       0
`define ST_DIGIT       1
`define ST_ZERO        2
`define ST_OVER        3
`define ST_NEG         4

// ----------------------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------------------
`define CT_EXT_EN      0
`define CT_BUSY        1
`define CT_BAD_OP      2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_WORK       8'h00
`define RST_STATUS     5'h00
`define RST_BANK_SEL   4'h0
`define RST_INDEX_BASE 12'h000

// ----------------------------------------------------------------------------
// Opcode patterns: upper byte of the 16-bit word, masks ignore d and a
// ----------------------------------------------------------------------------
`define OP_MASK_FILE   8'hFC
`define OP_WORK_FILE   8'h5C
`define OP_FILE_BORROW 8'h54
`define OP_WORK_LIT    8'h08
`define OP_BIT_DEST    9
`define OP_BIT_ACCESS  8

// ----------------------------------------------------------------------------
// Access bank split and high half of the access bank
// ----------------------------------------------------------------------------
`define ACC_LOW_LAST   8'h5F
`define ACC_HIGH_PAGE  4'hF

// ----------------------------------------------------------------------------
// AXI response codes
// ----------------------------------------------------------------------------
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### sub_flag_unit.v
// Eight-bit subtractor with borrow and full flag generation.
// Assumes operands are stable for the cycle in which the result is taken.
`timescale 1ns/1ps
module sub_flag_unit #(
  parameter WIDTH = 8                        // Operand width.
) (
  // Operands
  input  wire [WIDTH-1:0] minuend,           // Value subtracted from.
  input  wire [WIDTH-1:0] subtrahend,        // Value taken away.
  input  wire             carry_in,          // Inverted borrow in, 1 means none.
  // Result and flags
  output wire [WIDTH-1:0] result,            // Wrapped difference.
  output wire             carry_out,         // Inverted borrow out.
  output wire             digit_carry,       // Inverted borrow out of low nibble.
  output wire             overflow,          // Signed overflow.
  output wire             negative,          // Sign of result.
  output wire             zero               // Result is zero.
);

  // Two's complement: add the inverted subtrahend plus the carry.
  wire [WIDTH:0] full_sum;                   // Sum with carry out.
  wire [4:0]     low_sum;                    // Low nibble sum with carry out.

  assign full_sum    = {1'b0, minuend} + {1'b0, ~subtrahend} + {{WIDTH{1'b0}}, carry_in};
  assign low_sum     = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
  assign result      = full_sum[WIDTH-1:0];
  assign carry_out   = full_sum[WIDTH];
  assign digit_carry = low_sum[4];
  assign overflow    = (minuend[WIDTH-1] != subtrahend[WIDTH-1]) &&
                       (result[WIDTH-1] != minuend[WIDTH-1]);
  assign negative    = result[WIDTH-1];
  assign zero        = (result == {WIDTH{1'b0}});

endmodule

// ### tb_byte_subtract_instructions.sv
// Self-checking bench for the subtract core, driven over its register bus.
// Assumes the core's register map and a 40 MHz clock.
`timescale 1ns/1ps
`include "sub_exec_defs.vh"
module tb_byte_subtract_instructions;
  reg         aclk = 1'b0;                   // Core clock.
  reg         aresetn = 1'b0;                // Reset, active low.
  reg  [7:0]  awaddr = 8'h00;
  reg         awvalid = 1'b0;
  reg  [31:0] wdata = 32'h0;
  reg  [3:0]  wstrb = 4'h0;
  reg         wvalid = 1'b0;
  reg         bready = 1'b0;
  reg  [7:0]  araddr = 8'h00;
  reg         arvalid = 1'b0;
  reg         rready = 1'b0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  reg  [31:0] rd_val;                        // Last read data.
  reg  [1:0]  rsp;                           // Last response code.
  int         errors = 0;
  int         n_compared = 0;
  always #12.5 aclk = ~aclk;
  sub_exec_core #(.ADDR_W(12)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  // ---------------------------------------------------------------------------
  // Reporting and bus tasks
  // ---------------------------------------------------------------------------
  task test_done;
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Handshakes are sampled at the edge, before this edge's updates land.
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, output [1:0] r);
    int n;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 100)
    begin
      errors++;
      test_done;
    end
  endtask
  task automatic rd(input [7:0] a, output [31:0] d, output [1:0] r);
    int n;
    r = 2'h3;
    d = 32'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 100)
    begin
      errors++;
      test_done;
    end
  endtask
  // Expected status word for minuend minus subtrahend minus inverted carry.
  function automatic [31:0] flags(input [7:0] m, input [7:0] s, input ci);
    reg [8:0] full;
    reg [4:0] lo;
    full = {1'b0, m} - {1'b0, s} - {8'h00, !ci};
    lo = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, !ci};
    flags = {27'h0, full[7], (m[7] != s[7]) && (full[7] != m[7]), full[7:0] == 8'h00,
             !lo[4], !full[8]};
  endfunction
  // Loads operands, runs one word, waits for busy to clear, checks everything.
  task automatic exec(input [15:0] op, input [11:0] fa, input [7:0] w0, input [7:0] f0,
                      input c0);
    reg [7:0] m, s, r;
    reg       ci, to_w;
    int       n;
    m = (op[15:8] == 8'h08) ? op[7:0] : f0;
    s = w0;
    ci = 1'b1;
    if (op[15:10] == 6'h15)
    begin
      m = w0;
      s = f0;
      ci = c0;
    end
    r = m - s - {7'h00, !ci};
    to_w = (op[15:8] == 8'h08) || !op[9];
    wr(`OFS_WORK, {24'h0, w0}, 4'hF, rsp);
    wr(`OFS_MEM_ADDR, {20'h0, fa}, 4'hF, rsp);
    wr(`OFS_MEM_DATA, {24'h0, f0}, 4'hF, rsp);
    wr(`OFS_STATUS, {31'h0, c0}, 4'hF, rsp);
    wr(`OFS_INSTR, {16'h0, op}, 4'hF, rsp);
    for (n = 0; n < 20; n++)
    begin
      rd(`OFS_CTRL, rd_val, rsp);
      if (rd_val[`CT_BUSY] === 1'b0)
        break;
    end
    // Four phases: busy still stands at the first poll and is gone at the second.
    chk(n, 1);
    rd(`OFS_WORK, rd_val, rsp);
    chk(rd_val, {24'h0, to_w ? r : w0});
    rd(`OFS_MEM_DATA, rd_val, rsp);
    chk(rd_val, {24'h0, to_w ? f0 : r});
    rd(`OFS_STATUS, rd_val, rsp);
    chk(rd_val, flags(m, s, ci));
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task t_regs;
    reg [7:0] ofs [5] = '{`OFS_WORK, `OFS_STATUS, `OFS_BANK_SEL, `OFS_CTRL, `OFS_INDEX_BASE};
    foreach (ofs[i])
    begin
      rd(ofs[i], rd_val, rsp);
      chk(rd_val, 32'h0);
    end
    rd(8'h20, rd_val, rsp);
    chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    rd(8'h05, rd_val, rsp);
    chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(8'h24, 32'h1, 4'hF, rsp);
    chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(`OFS_WORK, 32'h55, 4'h0, rsp);
    rd(`OFS_WORK, rd_val, rsp);
    chk(rd_val, 32'h0);
  endtask
  task t_sub_work_from_file;
    exec(16'h5E10, 12'h010, 8'h02, 8'h03, 1'b0);
    exec(16'h5C10, 12'h010, 8'h02, 8'h02, 1'b0);
    exec(16'h5E10, 12'h010, 8'h02, 8'h01, 1'b1);
  endtask
  task t_sub_work_from_literal;
    exec(16'h0802, 12'h011, 8'h01, 8'hA5, 1'b0);
    exec(16'h0802, 12'h011, 8'h02, 8'hA5, 1'b0);
    exec(16'h0802, 12'h011, 8'h03, 8'hA5, 1'b1);
    exec(16'h0880, 12'h011, 8'h01, 8'hA5, 1'b1);
  endtask
  task t_sub_file_from_work_borrow;
    exec(16'h5620, 12'h020, 8'h02, 8'h03, 1'b1);
    exec(16'h5420, 12'h020, 8'h05, 8'h02, 1'b1);
    exec(16'h5620, 12'h020, 8'h02, 8'h01, 1'b0);
  endtask
  task t_bank;
    wr(`OFS_BANK_SEL, 32'h3, 4'hF, rsp);
    exec(16'h5F10, 12'h310, 8'h0D, 8'h19, 1'b1);
    exec(16'h5E10, 12'h010, 8'h0E, 8'h03, 1'b1);
    exec(16'h5E80, 12'hF80, 8'h1A, 8'h1B, 1'b0);
  endtask
  task t_ext;
    wr(`OFS_CTRL, 32'h1, 4'hF, rsp);
    wr(`OFS_INDEX_BASE, 32'h200, 4'hF, rsp);
    exec(16'h5E5F, 12'h25F, 8'h04, 8'h09, 1'b1);
    exec(16'h5E60, 12'hF60, 8'h09, 8'h04, 1'b1);
    exec(16'h5F05, 12'h305, 8'h01, 8'h80, 1'b1);
    wr(`OFS_CTRL, 32'h0, 4'hF, rsp);
  endtask
  task t_badop;
    // A write right behind an instruction lands in its last phase and is refused.
    wr(`OFS_INSTR, 32'h0802, 4'hF, rsp);
    wr(`OFS_WORK, 32'h3C, 4'hF, rsp);
    chk({30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(`OFS_WORK, 32'h3C, 4'hF, rsp);
    wr(`OFS_INSTR, 32'hFFFF, 4'hF, rsp);
    rd(`OFS_WORK, rd_val, rsp);
    chk(rd_val, 32'h3C);
    rd(`OFS_CTRL, rd_val, rsp);
    chk({31'h0, rd_val[`CT_BAD_OP]}, 32'h1);
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_sub_work_from_file;
    t_sub_work_from_literal;
    t_sub_file_from_work_borrow;
    t_bank;
    t_ext;
    t_badop;
    test_done;
  end
endmodule
